/* File: line_side_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// Free-running line timing and a serial data pattern, count bit 0 XOR count bit 5.
module line_side_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  output logic      [4:0] slot_o,
  output logic      [2:0] bit_o,
  output logic      [3:0] frame_o,
  output logic            fbit_time_o,
  output logic            serial_o
);
  logic [11:0] pos_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pos_ff <= 12'h000;
    else
      pos_ff <= pos_ff + 12'h001;
  end

  assign {frame_o, slot_o, bit_o} = pos_ff;
  assign fbit_time_o = (slot_o == 5'h00) && (bit_o == 3'h0);
  assign serial_o = pos_ff[0] ^ pos_ff[5];
endmodule : line_side_model

/* File: testbench.sv */
`timescale 1ns/1ps
// ==========================================================================
// Register-level test of the overhead control block.
module testbench;
  import tx_overhead_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [10:0] wb_adr_i = 11'h000;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, fbit_time_i, tx_serial_data_in_i;
  logic [4:0]  slot_i;
  logic [2:0]  bit_i;
  logic [3:0]  frame_i;
  logic        framer_active_o, low_power_o, core_reset_o, e1_mode_o, tx_japan_crc6_sel_o;
  logic        fbit_from_serial_o, crc6_from_serial_o, soft_signaling_active_o;
  logic        b7_stuff_all_o, b7_stuff_per_channel_o, zero_subst_en_o, b8zs_en_o, hdb3_en_o;
  logic        all_ones_alarm_o, remote_alarm_t1_o, slot0_from_serial_o, crc4_gen_en_o;
  logic        slot16_from_soft_regs_o, tx_channel_block_out_o, si_from_regs_o;
  logic        slot16_all_ones_o, spare5_bit_o, spare6_bit_o, spare7_bit_o, spare8_bit_o;
  logic [7:0]  per_channel_signaling_en_o, soft_signaling_regs_o, q;
  logic [8:0]  regs [7] = '{OFS_SPARE5, OFS_SPARE6, OFS_SPARE7, OFS_SPARE8, OFS_MASTER,
                            OFS_CTRL_ONE, OFS_CTRL_TWO};
  logic [3:0]  fr [3] = '{4'hF, 4'h1, 4'h2};
  logic [7:0]  sp [3] = '{8'h09, 8'h06, 8'h00};
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          n;

  always #12.5 clk_i = ~clk_i;

  tx_framer_overhead_control tx_framer_overhead_control_i (.*);
  line_side_model line_side_model_i (.clk_i(clk_i), .rst_i(rst_i), .slot_o(slot_i),
    .bit_o(bit_i), .frame_o(frame_i), .fbit_time_o(fbit_time_i), .serial_o(tx_serial_data_in_i));

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Classic single cycle; holds everything until ack is sampled high.
  task automatic bus(input logic w, input logic [8:0] ofs, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'h1;
    wb_adr_i <= {ofs, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1)
    begin
      error_cnt++;
      tally_and_finish();
    end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [8:0] ofs, input logic [7:0] e, input string nm);
    bus(1'b0, ofs, 8'h00);
    chk(nm, e, q);
  endtask : rd

  task automatic step();
    @(posedge clk_i);
    #1;
    n++;
    if (n > 5000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : step

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (regs[i]) rd(regs[i], RESET_BYTE, "reset value");
    bus(1'b1, 9'h100, 8'hFF);
    rd(9'h100, 8'h00, "unmapped");
    bus(1'b1, OFS_MASTER, 8'h01);
    bus(1'b1, OFS_SPARE5, 8'h80);
    bus(1'b1, OFS_SPARE6, 8'h7F);
    bus(1'b1, OFS_SPARE7, 8'h01);
    bus(1'b1, OFS_SPARE8, 8'hFE);
    bus(1'b1, OFS_CTRL_ONE, 8'h2D);
    bus(1'b1, OFS_MASTER, 8'h81);
    bus(1'b1, OFS_MASTER, 8'hC1);
    rd(OFS_SPARE6, 8'h7F, "spare6");
    rd(OFS_CTRL_ONE, 8'h2D, "e1 ctrl");
    chk("e1 flags", 8'hBC, {hdb3_en_o, b8zs_en_o, zero_subst_en_o, crc4_gen_en_o, e1_mode_o,
      framer_active_o, low_power_o, remote_alarm_t1_o});
    for (int i = 0; i < 3; i++)
    begin
      n = 0;
      do step(); while (frame_i !== fr[i]);
      chk("spare bits", sp[i],
        {4'h0, spare5_bit_o, spare6_bit_o, spare7_bit_o, spare8_bit_o});
    end
    n = 0;
    do step(); while (!(slot_i === G802_SLOT && bit_i === 3'h1));
    chk("chan block", 8'h01, {7'h00, tx_channel_block_out_o});
    bus(1'b1, OFS_MASTER, 8'hC3);
    rd(OFS_CTRL_ONE, 8'h00, "cleared ctrl");
    chk("soft reset", 8'h01, {7'h00, core_reset_o});
    bus(1'b1, OFS_MASTER, 8'h80);
    rd(OFS_SPARE5, 8'h00, "cleared spare");
    bus(1'b1, OFS_CTRL_ONE, 8'hFF);
    bus(1'b1, OFS_CTRL_TWO, 8'h01);
    bus(1'b1, OFS_MASTER, 8'hC0);
    rd(OFS_CTRL_TWO, 8'h01, "ctrl2");
    chk("t1 flags", 8'hBE, {b8zs_en_o, hdb3_en_o, remote_alarm_t1_o, all_ones_alarm_o,
      tx_japan_crc6_sel_o, soft_signaling_active_o, b7_stuff_all_o,
      b7_stuff_per_channel_o});
    chk("t1 sources", 8'h02, {6'h00, fbit_from_serial_o, crc4_gen_en_o});
    bus(1'b1, OFS_CTRL_ONE, 8'hF7);
    rd(OFS_CTRL_ONE, 8'hF7, "t1 ctrl");
    chk("stuff sel", 8'h03, {5'h00, b7_stuff_all_o, b7_stuff_per_channel_o,
      soft_signaling_active_o});
    n = 0;
    do step(); while (fbit_time_i !== 1'b1);
    chk("crc6 pass", 8'h01, {7'h00, crc6_from_serial_o});
    step();
    chk("crc6 idle", 8'h00, {7'h00, crc6_from_serial_o});
    bus(1'b1, OFS_CTRL_TWO, 8'h00);
    rd(OFS_CTRL_TWO, 8'h00, "ctrl2 off");
    chk("no stuff", 8'h00, {5'h00, b7_stuff_all_o, b7_stuff_per_channel_o,
      soft_signaling_active_o});
    bus(1'b1, OFS_MASTER, 8'h41);
    rd(OFS_CTRL_ONE, 8'h00, "e1 copy");
    chk("framer off", 8'h01, {6'h00, framer_active_o, low_power_o});
    bus(1'b1, OFS_CTRL_ONE, 8'h58);
    bus(1'b1, OFS_SIG_ENABLE, 8'hA5);
    bus(1'b1, OFS_SOFT_SIG, 8'h3C);
    bus(1'b1, OFS_MASTER, 8'hC1);
    rd(OFS_STATUS, 8'h05, "status");
    chk("e1 sources", 8'h06, {4'h0, slot0_from_serial_o, slot16_from_soft_regs_o,
      si_from_regs_o, crc4_gen_en_o});
    chk("sig enables", 8'hA5, per_channel_signaling_en_o);
    chk("soft sig regs", 8'h3C, soft_signaling_regs_o);
    n = 0;
    do step(); while (slot_i !== SLOT_SIXTEEN);
    chk("slot16 ones", 8'h01, {7'h00, slot16_all_ones_o});
    bus(1'b1, OFS_CTRL_ONE, 8'h80);
    chk("slot0 pass", 8'h08, {4'h0, slot0_from_serial_o, slot16_from_soft_regs_o,
      si_from_regs_o, crc4_gen_en_o});
    tally_and_finish();
  end
endmodule : testbench

bind tx_framer_overhead_control tx_overhead_checker tx_overhead_checker_i (.*);

/* File: tx_framer_overhead_control.sv */
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
// Summary of operation
// - Spare registers give odd-frame Sa5..Sa8 bits.
// - Framer enable clear holds framer in low power.
// - Init done starts framer when enabled.
// - Soft reset level holds transceiver in reset.
// - Mode bit selects T1 or E1 transmitter.
// - Japan CRC bit selects CRC-6 method.
// - F-bit pass takes framing from serial input.
// - CRC pass takes CRC-6 from serial input.
// - Soft signaling gated by bit-7 suppression enable.
// - Global stuffing stuffs every all-zero channel.
// - Bit 2 enables B8ZS or HDB3.
// - Alarm bit sends unframed all ones.
// - T1 remote alarm follows bit 0.
// - Slot 0 pass selects serial overhead source.
// - Slot 16 select picks software signaling.
// - G.802 forces channel block in slot 26.
// - Intl select picks Si source.
// - Signaling all-ones forces slot 16 ones.
// - E1 bit 0 enables CRC-4.
// - Bit-7 suppression enable allows any stuffing.
module tx_framer_overhead_control
  import tx_overhead_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [10:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [4:0]  slot_i,
  input  wire logic [2:0]  bit_i,
  input  wire logic [3:0]  frame_i,
  input  wire logic        fbit_time_i,
  input  wire logic        tx_serial_data_in_i,
  output logic             framer_active_o,
  output logic             low_power_o,
  output logic             core_reset_o,
  output logic             e1_mode_o,
  output logic             tx_japan_crc6_sel_o,
  output logic             fbit_from_serial_o,
  output logic             crc6_from_serial_o,
  output logic             soft_signaling_active_o,
  output logic             b7_stuff_all_o,
  output logic             b7_stuff_per_channel_o,
  output logic             zero_subst_en_o,
  output logic             b8zs_en_o,
  output logic             hdb3_en_o,
  output logic             all_ones_alarm_o,
  output logic             remote_alarm_t1_o,
  output logic             slot0_from_serial_o,
  output logic             slot16_from_soft_regs_o,
  output logic             tx_channel_block_out_o,
  output logic             si_from_regs_o,
  output logic             slot16_all_ones_o,
  output logic             crc4_gen_en_o,
  output logic             spare5_bit_o,
  output logic             spare6_bit_o,
  output logic             spare7_bit_o,
  output logic             spare8_bit_o,
  output logic [7:0]       per_channel_signaling_en_o,
  output logic [7:0]       soft_signaling_regs_o
);

  // ==========================================================================
  // Registers.
  logic [7:0]  spare_ff [4];
  logic [7:0]  master_ff;
  logic [7:0]  ctrl_t1_ff;
  logic [7:0]  ctrl_e1_ff;
  logic [7:0]  ctrl_two_ff;
  logic [7:0]  sig_en_ff;
  logic [7:0]  soft_sig_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  run_state_t  state_ff;
  run_state_t  nxt_state;
  logic        serial_meta_ff;
  logic        serial_sync_ff;
  logic        block_ff;
  logic        wr_req;
  logic        rd_req;
  logic [8:0]  offset;
  logic [7:0]  rd_byte;
  logic        e1;
  logic        b7_en;
  logic        soft_rst;
  logic        run;
  logic [7:0]  ctrl_one;
  logic [3:0]  spare_bits;
  logic [3:0]  spare_out;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] d,
                                            input logic [3:0] sel);
    merge_byte = sel[0] ? d[7:0] : old_v;
  endfunction : merge_byte

  // ==========================================================================
  // Bus decode.
  assign offset   = wb_adr_i[10:2];
  assign wr_req   = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
  assign rd_req   = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;
  assign e1       = master_ff[MM_STANDARD];
  assign soft_rst = master_ff[MM_SOFT_RESET];
  assign run      = (state_ff == ST_RUN);
  assign ctrl_one = e1 ? ctrl_e1_ff : ctrl_t1_ff;
  assign b7_en    = ctrl_two_ff[T2_B7_ZS];

  // ==========================================================================
  // Register writes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      master_ff <= RESET_BYTE;
    end
    else if (wr_req && offset == OFS_MASTER)
    begin
      master_ff <= merge_byte(master_ff, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        spare_ff[i] <= RESET_BYTE;
      end
      ctrl_t1_ff  <= RESET_BYTE;
      ctrl_e1_ff  <= RESET_BYTE;
      ctrl_two_ff <= RESET_BYTE;
      sig_en_ff   <= RESET_BYTE;
      soft_sig_ff <= RESET_BYTE;
    end
    else if (wr_req)
    begin
      unique case (offset)
        OFS_SPARE5:     spare_ff[0] <= merge_byte(spare_ff[0], wb_dat_i, wb_sel_i);
        OFS_SPARE6:     spare_ff[1] <= merge_byte(spare_ff[1], wb_dat_i, wb_sel_i);
        OFS_SPARE7:     spare_ff[2] <= merge_byte(spare_ff[2], wb_dat_i, wb_sel_i);
        OFS_SPARE8:     spare_ff[3] <= merge_byte(spare_ff[3], wb_dat_i, wb_sel_i);
        OFS_CTRL_ONE:
        begin
          if (e1)
          begin
            ctrl_e1_ff <= merge_byte(ctrl_e1_ff, wb_dat_i, wb_sel_i);
          end
          else
          begin
            ctrl_t1_ff <= merge_byte(ctrl_t1_ff, wb_dat_i, wb_sel_i);
          end
        end
        OFS_CTRL_TWO:   ctrl_two_ff <= merge_byte(ctrl_two_ff, wb_dat_i, wb_sel_i);
        OFS_SIG_ENABLE: sig_en_ff   <= merge_byte(sig_en_ff, wb_dat_i, wb_sel_i);
        OFS_SOFT_SIG:   soft_sig_ff <= merge_byte(soft_sig_ff, wb_dat_i, wb_sel_i);
        default:        ;
      endcase
    end
  end

  // ==========================================================================
  // Bus read and acknowledge.
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (offset)
      OFS_SPARE5:     rd_byte = spare_ff[0];
      OFS_SPARE6:     rd_byte = spare_ff[1];
      OFS_SPARE7:     rd_byte = spare_ff[2];
      OFS_SPARE8:     rd_byte = spare_ff[3];
      OFS_MASTER:     rd_byte = master_ff;
      OFS_CTRL_ONE:   rd_byte = ctrl_one;
      OFS_CTRL_TWO:   rd_byte = ctrl_two_ff;
      OFS_SIG_ENABLE: rd_byte = sig_en_ff;
      OFS_SOFT_SIG:   rd_byte = soft_sig_ff;
      OFS_STATUS:     rd_byte = {5'h00, run, state_ff == ST_OFF, e1};
      OFS_FRAME_REF:  rd_byte = {4'h0, frame_i};
      default:        rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
      if (rd_req)
      begin
        rdata_ff <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ==========================================================================
  // Start-up sequence.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (master_ff[MM_INIT_DONE])
        begin
          nxt_state = master_ff[MM_FRAMER_ON] ? ST_RUN : ST_OFF;
        end
      end
      ST_OFF:
      begin
        if (master_ff[MM_FRAMER_ON])
        begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (!master_ff[MM_FRAMER_ON])
        begin
          nxt_state = ST_OFF;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (!master_ff[MM_INIT_DONE])
    begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst)
    begin
      state_ff <= ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // Serial input synchroniser and channel block output.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      serial_meta_ff <= 1'b0;
      serial_sync_ff <= 1'b0;
    end
    else
    begin
      serial_meta_ff <= tx_serial_data_in_i;
      serial_sync_ff <= serial_meta_ff;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      block_ff <= 1'b0;
    end
    else
    begin
      block_ff <= run && e1 && ctrl_e1_ff[E1_G802_EN] && slot_i == G802_SLOT
                  && bit_i == G802_BIT;
    end
  end

  // ==========================================================================
  // Spare bit selection.
  for (genvar g = 0; g < 4; g++)
  begin : g_spare
    tx_spare_select u_sel (
      .spare_reg_i (spare_ff[g]),
      .frame_i     (frame_i),
      .spare_bit_o (spare_bits[g])
    );
  end

  always_comb
  begin
    spare_out = 4'h0;
    if (slot0_from_serial_o)
    begin
      spare_out = {4{serial_sync_ff}};
    end
    else if (run && e1)
    begin
      spare_out = spare_bits;
    end
  end

  // ==========================================================================
  // Control outputs.
  assign framer_active_o         = run;
  assign low_power_o             = !run;
  assign core_reset_o            = soft_rst;
  assign e1_mode_o               = e1;
  assign tx_japan_crc6_sel_o     = run && !e1 && ctrl_t1_ff[T1_JAPAN_CRC];
  assign fbit_from_serial_o      = run && !e1 && ctrl_t1_ff[T1_FBIT_PASS];
  assign crc6_from_serial_o      = run && !e1 && ctrl_t1_ff[T1_CRC6_PASS]
                                   && fbit_time_i;
  assign soft_signaling_active_o = run && !e1 && b7_en
                                   && ctrl_t1_ff[T1_SOFT_SIG];
  assign b7_stuff_all_o          = run && !e1 && b7_en
                                   && ctrl_t1_ff[T1_GLOBAL_B7];
  assign b7_stuff_per_channel_o  = run && !e1 && b7_en
                                   && !ctrl_t1_ff[T1_GLOBAL_B7];
  assign zero_subst_en_o         = run && ctrl_one[ZERO_SUBST];
  assign b8zs_en_o               = zero_subst_en_o && !e1;
  assign hdb3_en_o               = zero_subst_en_o && e1;
  assign all_ones_alarm_o        = run && ctrl_one[ALL_ONES_AIS];
  assign remote_alarm_t1_o       = run && !e1 && ctrl_t1_ff[T1_REMOTE];
  assign slot0_from_serial_o     = run && e1 && ctrl_e1_ff[E1_SLOT0_PASS];
  assign slot16_from_soft_regs_o = run && e1 && ctrl_e1_ff[E1_SLOT16_SEL];
  assign tx_channel_block_out_o  = block_ff;
  assign si_from_regs_o          = run && e1 && ctrl_e1_ff[E1_INTL_SEL];
  assign slot16_all_ones_o       = run && e1 && ctrl_e1_ff[E1_SLOT16_ONE]
                                   && slot_i == SLOT_SIXTEEN;
  assign crc4_gen_en_o           = run && e1 && ctrl_e1_ff[E1_CRC4_EN];
  assign spare5_bit_o            = spare_out[0];
  assign spare6_bit_o            = spare_out[1];
  assign spare7_bit_o            = spare_out[2];
  assign spare8_bit_o            = spare_out[3];
  assign per_channel_signaling_en_o = sig_en_ff;
  assign soft_signaling_regs_o   = soft_sig_ff;

endmodule : tx_framer_overhead_control

/* File: tx_overhead_checker.sv */
`timescale 1ns/1ps
// ==========================================================================
// Port-level checks of the overhead control block.
module tx_overhead_checker
  import tx_overhead_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [10:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [4:0]  slot_i,
  input wire logic [2:0]  bit_i,
  input wire logic [3:0]  frame_i,
  input wire logic        framer_active_o,
  input wire logic        low_power_o,
  input wire logic        core_reset_o,
  input wire logic        e1_mode_o,
  input wire logic        b8zs_en_o,
  input wire logic        hdb3_en_o,
  input wire logic        zero_subst_en_o,
  input wire logic        all_ones_alarm_o,
  input wire logic        remote_alarm_t1_o,
  input wire logic        b7_stuff_all_o,
  input wire logic        b7_stuff_per_channel_o,
  input wire logic        tx_channel_block_out_o,
  input wire logic        slot16_all_ones_o,
  input wire logic        slot0_from_serial_o,
  input wire logic        spare5_bit_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_latency: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
  a_low_power: assert property (
    low_power_o |-> !framer_active_o && !(b8zs_en_o || hdb3_en_o || all_ones_alarm_o))
    else $error("outputs active in low power");
  a_run_start: assert property (
    $rose(wb_ack_o) && wb_we_i && wb_adr_i[10:2] == OFS_MASTER && wb_dat_i[7:6] == 2'b11
    && !wb_dat_i[1] |-> ##[1:2] framer_active_o) else $error("framer did not start");
  a_soft_level: assert property (
    wb_ack_o && wb_we_i && wb_adr_i[10:2] == OFS_MASTER
    |=> core_reset_o == $past(wb_dat_i[MM_SOFT_RESET])) else $error("soft reset level");
  a_t1_code: assert property (
    b8zs_en_o |-> zero_subst_en_o && !e1_mode_o) else $error("b8zs outside t1");
  a_e1_code: assert property (
    hdb3_en_o |-> zero_subst_en_o && e1_mode_o) else $error("hdb3 outside e1");
  a_remote_t1: assert property (
    remote_alarm_t1_o |-> !e1_mode_o && framer_active_o) else $error("remote alarm mode");
  a_stuff_excl: assert property (
    b7_stuff_all_o |-> !b7_stuff_per_channel_o) else $error("stuffing select clash");
  a_block_slot: assert property (
    tx_channel_block_out_o |-> $past(slot_i) == G802_SLOT && $past(bit_i) == G802_BIT)
    else $error("channel block timing");
  a_slot16_ones: assert property (
    slot16_all_ones_o |-> slot_i == SLOT_SIXTEEN && e1_mode_o) else $error("slot16 ones");
  a_spare_odd: assert property (
    spare5_bit_o && !slot0_from_serial_o |-> frame_i[0]) else $error("spare on even frame");

  c_block: cover property (tx_channel_block_out_o);
  c_e1_run: cover property (framer_active_o && e1_mode_o);
  c_stuff: cover property (b7_stuff_all_o);
  c_slot16: cover property (slot16_all_ones_o);
endmodule : tx_overhead_checker

/* File: tx_overhead_pkg.sv */
package tx_overhead_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [8:0] OFS_SPARE5     = 9'h16A;
  localparam logic [8:0] OFS_SPARE6     = 9'h16B;
  localparam logic [8:0] OFS_SPARE7     = 9'h16C;
  localparam logic [8:0] OFS_SPARE8     = 9'h16D;
  localparam logic [8:0] OFS_MASTER     = 9'h180;
  localparam logic [8:0] OFS_CTRL_ONE   = 9'h181;
  localparam logic [8:0] OFS_CTRL_TWO   = 9'h182;
  localparam logic [8:0] OFS_STATUS     = 9'h1F0;
  localparam logic [8:0] OFS_SIG_ENABLE = 9'h1F1;
  localparam logic [8:0] OFS_SOFT_SIG   = 9'h1F2;
  localparam logic [8:0] OFS_FRAME_REF  = 9'h1F3;

  // ==========================================================================
  // Field positions.
  localparam int MM_FRAMER_ON  = 7;
  localparam int MM_INIT_DONE  = 6;
  localparam int MM_SOFT_RESET = 1;
  localparam int MM_STANDARD   = 0;
  localparam int T1_JAPAN_CRC  = 7;
  localparam int T1_FBIT_PASS  = 6;
  localparam int T1_CRC6_PASS  = 5;
  localparam int T1_SOFT_SIG   = 4;
  localparam int T1_GLOBAL_B7  = 3;
  localparam int ZERO_SUBST    = 2;
  localparam int ALL_ONES_AIS  = 1;
  localparam int T1_REMOTE     = 0;
  localparam int E1_SLOT0_PASS = 7;
  localparam int E1_SLOT16_SEL = 6;
  localparam int E1_G802_EN    = 5;
  localparam int E1_INTL_SEL   = 4;
  localparam int E1_SLOT16_ONE = 3;
  localparam int E1_CRC4_EN    = 0;
  localparam int T2_B7_ZS      = 0;

  // ==========================================================================
  // Reset values and timing.
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [4:0] G802_SLOT    = 5'h1A;
  localparam logic [2:0] G802_BIT     = 3'h0;
  localparam logic [4:0] SLOT_SIXTEEN = 5'h10;

  typedef enum logic [1:0] {ST_IDLE, ST_OFF, ST_RUN} run_state_t;

endpackage : tx_overhead_pkg

/* File: tx_spare_select.sv */
`timescale 1ns/1ps
module tx_spare_select
  import tx_overhead_pkg::*;
(
  input  wire logic [7:0] spare_reg_i,
  input  wire logic [3:0] frame_i,
  output logic            spare_bit_o
);

  // ==========================================================================
  // Odd frame 2k+1 maps to bit k; even frames give zero.
  always_comb
  begin
    spare_bit_o = frame_i[0] ? spare_reg_i[frame_i[3:1]] : 1'b0;
  end

endmodule : tx_spare_select
